//--- rtl/phy_mgmt_serial_master.sv
// PHY management serial master with MII status qualification
// Function
// R01: Management clock divided, never above 2.5 MHz
// R02: One bit per management clock rising edge
// R03: All fields shifted most significant first
// R04: Active-low enable steers data line direction
// R05: PHY flags errored receive frame
// R06: PHY flags collision during transmit
// R07: Collision ignored in full duplex, gigabit
// R08: Carrier sense ignored full duplex, gigabit
// R09: Clause 22 frame, released read turnaround
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_serial_master (
  input  wire logic                I_SYS_CLK,
  input  wire logic                I_SYS_RST,
  input  wire logic [7:0]          i_half_div,
  input  wire logic                i_start,
  input  wire mgmt_pkg::mgmt_cmd_t i_cmd,
  input  wire logic                i_mdio_in,
  input  wire logic                i_full_duplex,
  input  wire logic                i_gigabit,
  input  wire mgmt_pkg::phy_stat_t i_phy_stat,
  output logic                     o_busy,
  output logic                     o_done,
  output logic [15:0]              o_rdata,
  output logic                     o_mdc,
  output logic                     o_mdio_out,
  output logic                     o_mdio_oen,
  output logic                     o_rx_err,
  output logic                     o_col,
  output logic                     o_crs
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE  = 2'b01,
    ST_BODY = 2'b10,
    ST_END  = 2'b11
  } state_t;

  state_t      state_r, state_nxt;
  logic        busy_r, busy_nxt;
  logic [5:0]  bit_r, bit_nxt;
  logic [31:0] shift_r, shift_nxt;
  logic        rd_r, rd_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        out_r, out_nxt;
  logic        oen_r, oen_nxt;
  logic        done_r, done_nxt;
  logic        mdc_r;
  logic        mdc_raw;
  logic        rise;
  logic        fall;
  logic        run;
  logic [7:0]  mdc_hold_r;
  logic [7:0]  mdc_hold_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Clock divider; held stopped between frames so each frame starts low
  // R01: divided management clock
  assign run = (state_r != ST_IDLE);
  mdc_divider u_div (
    .i_clk      (I_SYS_CLK),
    .i_rst      (I_SYS_RST),
    .i_run      (run),
    .i_half_div (i_half_div),
    .o_mdc      (mdc_raw),
    .o_rise     (rise),
    .o_fall     (fall)
  );

  // Cycles since the clock pin last moved; saturates so idle gaps stay legal
  always_comb begin
    if (mdc_raw != mdc_r) begin
      mdc_hold_nxt = 8'h00;
    end else if (mdc_hold_r != 8'hFF) begin
      mdc_hold_nxt = mdc_hold_r + 8'h01;
    end else begin
      mdc_hold_nxt = mdc_hold_r;
    end
  end

  // Clock level age register, feeds the rate check only
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      mdc_hold_r <= 8'hFF;
    end else begin
      mdc_hold_r <= mdc_hold_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer: data changes after falling edge, so it is stable at
  // the PHY's rising-edge sample; read data sampled on rising edge
  always_comb begin
    state_nxt = state_r;
    bit_nxt   = bit_r;
    shift_nxt = shift_r;
    rd_nxt    = rd_r;
    rdata_nxt = rdata_r;
    out_nxt   = out_r;
    oen_nxt   = oen_r;
    done_nxt  = 1'b0;
    case (state_r)
      ST_IDLE: begin
        oen_nxt = 1'b1;
        out_nxt = 1'b1;
        if (i_start) begin
          // R09: clause 22 field layout
          rd_nxt    = i_cmd.rd;
          shift_nxt = {mgmt_pkg::START_CODE,
                       i_cmd.rd ? mgmt_pkg::OP_READ : mgmt_pkg::OP_WRITE,
                       i_cmd.phy_addr, i_cmd.reg_addr, mgmt_pkg::TA_WRITE,
                       i_cmd.wdata};
          bit_nxt   = 6'h00;
          oen_nxt   = 1'b0;
          out_nxt   = 1'b1;
          state_nxt = ST_PRE;
        end
      end
      ST_PRE: begin
        // R02: one preamble bit per rising edge
        if (rise) begin
          if (bit_r == mgmt_pkg::PREAMBLE_BITS - 6'h01) begin
            bit_nxt   = 6'h00;
            state_nxt = ST_BODY;
          end else begin
            bit_nxt = bit_r + 6'h01;
          end
        end
      end
      ST_BODY: begin
        // R03: present top bit first, then shift left
        if (fall) begin
          out_nxt   = shift_r[31];
          shift_nxt = {shift_r[30:0], 1'b0};
          // R04: release line across read turnaround and data
          // R09: device releases during read turnaround
          oen_nxt   = rd_r && (bit_r >= mgmt_pkg::TA_FIRST_BIT);
        end
        if (rise) begin
          // R02: capture read bit on rising edge, msb first
          if (rd_r && bit_r > mgmt_pkg::TA_LAST_BIT + 6'h01) begin
            rdata_nxt = {rdata_r[14:0], i_mdio_in};
          end
          if (bit_r == mgmt_pkg::FRAME_BITS) begin
            state_nxt = ST_END;
          end
        end
        if (fall) begin
          bit_nxt = bit_r + 6'h01;
        end
      end
      ST_END: begin
        if (fall) begin
          oen_nxt   = 1'b1;
          out_nxt   = 1'b1;
          done_nxt  = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Busy registered so the pin comes straight from a flop
    busy_nxt = (state_nxt != ST_IDLE);
  end

  // Sequencer registers
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state_r <= ST_IDLE;
      bit_r   <= 6'h00;
      shift_r <= 32'h0000_0000;
      rd_r    <= 1'b0;
      rdata_r <= 16'h0000;
      out_r   <= 1'b1;
      oen_r   <= 1'b1;
      done_r  <= 1'b0;
      mdc_r   <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_r   <= bit_nxt;
      shift_r <= shift_nxt;
      rd_r    <= rd_nxt;
      rdata_r <= rdata_nxt;
      out_r   <= out_nxt;
      oen_r   <= oen_nxt;
      done_r  <= done_nxt;
      mdc_r   <= mdc_raw;
      busy_r  <= busy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PHY status qualification
  logic rx_err_r, col_r, crs_r;
  logic col_nxt, crs_nxt;
  logic half_slow;

  // Collision and carrier only meaningful in half duplex below gigabit
  always_comb begin
    half_slow = ~i_full_duplex & ~i_gigabit;
    // R07: collision gated off
    col_nxt = i_phy_stat.col & half_slow;
    // R08: carrier sense gated off
    crs_nxt = i_phy_stat.crs & half_slow;
  end

  // Status registers; receive error passed as driven by the PHY
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rx_err_r <= 1'b0;
      col_r    <= 1'b0;
      crs_r    <= 1'b0;
    end else begin
      rx_err_r <= i_phy_stat.rx_err;
      col_r    <= col_nxt;
      crs_r    <= crs_nxt;
    end
  end

  assign o_busy     = busy_r;
  assign o_done     = done_r;
  assign o_rdata    = rdata_r;
  assign o_mdc      = mdc_r;
  assign o_mdio_out = out_r;
  assign o_mdio_oen = oen_r;
  assign o_rx_err   = rx_err_r;
  assign o_col      = col_r;
  assign o_crs      = crs_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_col_gated: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R07
    (i_full_duplex || i_gigabit) |=> !o_col)
    else $error("collision passed in full duplex or gigabit");
  a_crs_gated: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R08
    (i_full_duplex || i_gigabit) |=> !o_crs)
    else $error("carrier sense passed in full duplex or gigabit");
  a_col_passed: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R06
    (!i_full_duplex && !i_gigabit && i_phy_stat.col) |=> o_col)
    else $error("collision lost in half duplex");
  a_rxerr_follow: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R05
    i_phy_stat.rx_err |=> o_rx_err)
    else $error("receive error not reported");
  a_mdc_slow: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R01
    (mdc_raw != mdc_r) |-> (mdc_hold_r >= mgmt_pkg::DIV_RESET - 8'h01))
    else $error("management clock too fast");
  a_data_stable: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R02
    $rose(o_mdc) |-> $stable(o_mdio_out))
    else $error("data changed at rising edge");
  a_idle_release: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R04
    (state_r == ST_IDLE && !i_start) |=> o_mdio_oen)
    else $error("line driven while idle");
  a_write_drive: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R09
    (state_r == ST_BODY && !rd_r) |-> !o_mdio_oen)
    else $error("write frame released line");
  a_msb_first: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R03
    (state_r == ST_BODY && fall) |=> o_mdio_out == $past(shift_r[31]))
    else $error("bit order not msb first");
endmodule
`default_nettype wire

//--- rtl/mgmt_pkg.sv
// Package: constants and carriers for the PHY management serial master
package mgmt_pkg;
  // Management clock ceiling and system clock rate
  localparam int unsigned MDC_MAX_KHZ   = 2500;
  localparam int unsigned SYS_CLK_KHZ   = 125000;
  // Least half-period count that keeps the management clock at or below its ceiling
  localparam int unsigned MIN_HALF_DIV  = (SYS_CLK_KHZ + 2 * MDC_MAX_KHZ - 1) / (2 * MDC_MAX_KHZ);
  localparam logic [7:0]  DIV_RESET     = 8'(MIN_HALF_DIV);
  // Frame field widths and constants
  localparam logic [5:0]  FRAME_BITS    = 6'h20;
  localparam logic [5:0]  PREAMBLE_BITS = 6'h20;
  localparam logic [1:0]  START_CODE    = 2'h1;
  localparam logic [1:0]  OP_WRITE      = 2'h1;
  localparam logic [1:0]  OP_READ       = 2'h2;
  localparam logic [1:0]  TA_WRITE      = 2'h2;
  // Bit index where the turnaround begins, counted from the first start bit after the preamble
  localparam logic [5:0]  TA_FIRST_BIT  = 6'h0E;
  localparam logic [5:0]  TA_LAST_BIT   = 6'h0F;

  // Command carrier
  typedef struct packed {
    logic        rd;
    logic [4:0]  phy_addr;
    logic [4:0]  reg_addr;
    logic [15:0] wdata;
  } mgmt_cmd_t;

  // Phy status carrier
  typedef struct packed {
    logic rx_err;
    logic col;
    logic crs;
  } phy_stat_t;
endpackage

//--- rtl/mdc_divider.sv
// Management clock divider producing rise and fall strobes
`timescale 1ns/1ps
`default_nettype none
module mdc_divider (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_run,
  input  wire logic [7:0] i_half_div,
  output logic            o_mdc,
  output logic            o_rise,
  output logic            o_fall
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       mdc_r;
  logic       mdc_nxt;
  logic [7:0] half;

  // Divisor below the safe least value is clamped, never faster
  always_comb begin
    half = (i_half_div < mgmt_pkg::DIV_RESET) ? mgmt_pkg::DIV_RESET : i_half_div;
    cnt_nxt = cnt_r;
    mdc_nxt = mdc_r;
    o_rise = 1'b0;
    o_fall = 1'b0;
    if (!i_run) begin
      cnt_nxt = 8'h00;
      mdc_nxt = 1'b0;
    end else if (cnt_r == half - 8'h01) begin
      cnt_nxt = 8'h00;
      mdc_nxt = ~mdc_r;
      o_rise = ~mdc_r;
      o_fall = mdc_r;
    end else begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  // Divider state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= 8'h00;
      mdc_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      mdc_r <= mdc_nxt;
    end
  end

  assign o_mdc = mdc_r;
endmodule
`default_nettype wire

//--- verification/mgmt_phy_model.sv
// Behavioural PHY on the far side of the management link
`timescale 1ns/1ps
`default_nettype none
module mgmt_phy_model (
  input  wire logic        i_rst,
  input  wire logic        i_mdc,
  input  wire logic        i_line,
  output logic             o_oe,
  output logic             o_val,
  output logic [4:0]       o_pa,
  output logic [4:0]       o_ra,
  output logic [15:0]      o_wd
);
  logic [15:0] mem [32];
  logic [13:0] hdr;
  logic [15:0] sh;
  logic        rd_op;
  int          ones;
  int          idx;
  // Register contents before any write
  initial foreach (mem[i]) mem[i] = 16'hC3A5;
  ////////////////////////////////////////////////////////////////
  // sample on rise, msb first, after 32-one preamble
  always @(posedge i_mdc or posedge i_rst) begin
    if (i_rst) begin
      ones = 0;
      idx = 0;
    end else if (idx == 0) begin
      if (!i_line && ones >= 32) begin
        idx = 1;
        hdr = 14'h0000;
      end
      ones = i_line ? ones + 1 : 0;
    end else begin
      idx++;
      if (idx <= 14) hdr = {hdr[12:0], i_line};
      sh = {sh[14:0], i_line};
      if (idx == 14) begin
        o_pa = hdr[9:5];
        o_ra = hdr[4:0];
        rd_op = (hdr[11:10] == 2'h2);
      end
      if (idx == 32) begin
        if (!rd_op) mem[o_ra] = sh;
        if (!rd_op) o_wd = sh;
        idx = 0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // drive on fall so bits are stable at the next rise
  always @(negedge i_mdc or posedge i_rst) begin
    if (i_rst) begin
      o_oe = 1'b0;
    end else begin
      o_oe = rd_op && idx >= 15 && idx <= 31;
      o_val = (idx == 15) ? 1'b0 : mem[o_ra][(31 - idx) & 15];
    end
  end
endmodule
`default_nettype wire

//--- verification/phy_mgmt_serial_master_tb_top.sv
// Self-checking bench for the management serial master
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_serial_master_tb_top;
  typedef struct packed {
    mgmt_pkg::mgmt_cmd_t c;
    logic [7:0]          d;
    logic [15:0]         e;
  } row_t;
  logic sys_clk = 0, sys_rst = 1, start = 0, fd = 0, gb = 0, mdc_q = 0, line;
  logic [7:0] half_div = 8'h19;
  mgmt_pkg::mgmt_cmd_t cmd = '0;
  mgmt_pkg::phy_stat_t stat = '0;
  logic o_busy, o_done, o_mdc, o_mdio_out, o_mdio_oen, o_rx_err, o_col, o_crs, p_oe, p_val;
  logic [15:0] o_rdata, p_wd;
  logic [4:0]  p_pa, p_ra;
  int errors = 0, tests_run = 0, cyc = 0, per = 0, hd;
  bit have = 0;
  row_t rows [5] = '{
    '{'{1'b0, 5'h01, 5'h02, 16'h8001}, 8'h19, 16'h8001},
    '{'{1'b1, 5'h01, 5'h02, 16'h0000}, 8'h1A, 16'h8001},
    '{'{1'b0, 5'h1F, 5'h1F, 16'h7FFE}, 8'h08, 16'h7FFE},
    '{'{1'b1, 5'h1F, 5'h1F, 16'h0000}, 8'h28, 16'h7FFE},
    '{'{1'b1, 5'h00, 5'h05, 16'h0000}, 8'h19, 16'hC3A5}};
  // Line is pulled up; either party may pull it
  assign line = (o_mdio_oen ? 1'b1 : o_mdio_out) & (p_oe ? p_val : 1'b1);
  phy_mgmt_serial_master dut (.I_SYS_CLK(sys_clk), .I_SYS_RST(sys_rst), .i_half_div(half_div),
    .i_start(start), .i_cmd(cmd), .i_mdio_in(line), .i_full_duplex(fd), .i_gigabit(gb),
    .i_phy_stat(stat), .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata), .o_mdc(o_mdc),
    .o_mdio_out(o_mdio_out), .o_mdio_oen(o_mdio_oen), .o_rx_err(o_rx_err), .o_col(o_col),
    .o_crs(o_crs));
  mgmt_phy_model phy (.i_rst(sys_rst), .i_mdc(o_mdc), .i_line(line), .o_oe(p_oe),
    .o_val(p_val), .o_pa(p_pa), .o_ra(p_ra), .o_wd(p_wd));
  initial forever #4 sys_clk = ~sys_clk;
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task give_verdict;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Period watch; the clamp keeps fast settings legal, slow ones pass as set
  always @(posedge sys_clk) begin
    cyc++;
    per++;
    if (cyc > 40000) begin
      errors++;
      give_verdict();
    end
    // device must release while the PHY drives
    if (p_oe) chk("oen", 16'h1, {15'h0, o_mdio_oen});
    // A gap between frames is not a period
    if (o_busy !== 1'b1) have = 0;
    if (o_mdc && !mdc_q) begin
      if (have && o_busy) chk("period", 16'(2 * hd), 16'(per));
      have = o_busy;
      per = 0;
    end
    mdc_q = o_mdc;
  end
  task run(input row_t r, input bit intf);
    int k;
    hd = (r.d < mgmt_pkg::MIN_HALF_DIV) ? mgmt_pkg::MIN_HALF_DIV : r.d;
    @(posedge sys_clk);
    half_div <= r.d;
    cmd <= r.c;
    start <= 1;
    @(posedge sys_clk);
    start <= 0;
    @(negedge sys_clk);
    chk("busy", 16'h1, {15'h0, o_busy});
    if (intf) begin
      repeat (100) @(posedge sys_clk);
      cmd <= '{1'b0, 5'h04, 5'h04, 16'h5678};
      start <= 1;
      @(posedge sys_clk);
      start <= 0;
    end
    k = 0;
    while (o_done !== 1'b1 && k < 8000) begin
      @(negedge sys_clk);
      k++;
    end
    chk("done", 16'h1, {15'h0, o_done});
    chk("idle", 16'h0, {15'h0, o_busy});
    if (r.c.rd) chk("rdata", r.e, o_rdata);
    else chk("wdata", r.e, p_wd);
    chk("addr", {6'h00, r.c.phy_addr, r.c.reg_addr}, {6'h00, p_pa, p_ra});
    @(negedge sys_clk);
    chk("pulse", 16'h0, {15'h0, o_done});
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 0;
    foreach (rows[i]) run(rows[i], 0);
    // Start while busy is ignored
    run('{'{1'b0, 5'h02, 5'h03, 16'h1234}, 8'h19, 16'h1234}, 1);
    // Mode qualification of collision and carrier
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk);
      {fd, gb} <= 2'(m);
      stat <= {m[0], 2'b11};
      repeat (2) @(negedge sys_clk);
      chk("rxerr", 16'(m[0]), {15'h0, o_rx_err});
      chk("col", 16'(m == 0), {15'h0, o_col});
      chk("crs", 16'(m == 0), {15'h0, o_crs});
    end
    // Reset in mid-frame returns the link to idle
    @(posedge sys_clk);
    cmd <= '{1'b1, 5'h01, 5'h02, 16'h0000};
    start <= 1;
    @(posedge sys_clk);
    start <= 0;
    repeat (900) @(posedge sys_clk);
    sys_rst <= 1;
    repeat (2) @(negedge sys_clk);
    chk("rst", 16'h2, {13'h0, o_mdc, o_mdio_oen, o_busy});
    chk("rst_rdata", 16'h0000, o_rdata);
    chk("rst_stat", 16'h0, {13'h0, o_rx_err, o_col, o_crs});
    @(posedge sys_clk);
    sys_rst <= 0;
    run('{'{1'b0, 5'h03, 5'h09, 16'hA00F}, 8'h19, 16'hA00F}, 0);
    give_verdict();
  end
endmodule
`default_nettype wire
